// ---- verif/line_translator.sv ----
/* Far-side line driver model: folds a ones/zeros pair into three levels.
   Assumes lines settle on the system clock. */
`timescale 1ns/1ns
module line_translator (
  // Clock and line pair
  input  wire logic        clk_in,
  input  wire logic        ones_in,
  input  wire logic        zeros_in,
  // Bus level and decoded word
  output logic [1:0]       level_out,
  output logic [31:0]      word_out = 32'h0,
  output logic [5:0]       bits_out = 6'h0
);
  logic [1:0] prev_ff = 2'h0;
  // Three levels, null between pulses; 3 stands for minus one
  assign level_out = ones_in ? 2'h1 : (zeros_in ? 2'h3 : 2'h0);
  // Each new pulse adds a bit, lowest bit first
  always @(posedge clk_in) begin
    prev_ff <= {ones_in, zeros_in};
    if ((ones_in & !prev_ff[1]) | (zeros_in & !prev_ff[0])) begin
      word_out <= {ones_in, word_out[31:1]};
      bits_out <= bits_out + 6'h1;
    end
  end
endmodule : line_translator

// ---- verif/tb_transmit_channel_unit.sv ----
/* Bench: queue fill, flush, reset values and two looped-back serial words.
   Assumes checker and line model compile first. */
`timescale 1ns/1ns
module tb_transmit_channel_unit;
  logic clk_in = 1'b0, rst_n_in = 1'b0, ref_clk = 1'b0, sel_n = 1'b1, rw = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdat = 16'h0, rdat, rd;
  logic ack_n, oe_n, irq, lo, lz, ext = 1'b0;
  logic [2:0] ones, zeros;
  logic [31:0] rx_word;
  logic [5:0] rx_bits;
  int error_cnt = 0, checks = 0;
  // Reference clock runs free, unrelated to the system clock
  initial forever #25 clk_in = ~clk_in;
  initial forever #210 ref_clk = ~ref_clk;
  transmit_channel_unit transmit_channel_unit_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .avionics_reference_clock_in(ref_clk), .bus_sel_n_in(sel_n),
    .bus_rw_in(rw), .upper_ds_n_in(sel_n), .lower_ds_n_in(sel_n), .bus_addr_in(addr),
    .bus_data_in(wdat), .bus_data_out(rd), .bus_data_oe_n_out(oe_n), .bus_ack_n_out(ack_n),
    .tx_irq_mask_in(6'h3F), .transmit_interrupt_request_out(irq), .tx_ones_line_out(ones),
    .tx_zeros_line_out(zeros), .loopback_ones_line_out(lo), .loopback_zeros_line_out(lz));
  line_translator line_translator_i (.clk_in(clk_in), .ones_in(lo), .zeros_in(lz),
    .level_out(), .word_out(rx_word), .bits_out(rx_bits));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait so a dead handshake shows up as a mismatch
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
    end while (ack_n !== lvl && n < 30);
    chk(ack_n, lvl);
  endtask : wait_ack
  task automatic acc(input logic r, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #5 {sel_n, rw, addr, wdat} = {1'b0, r, a, d};
    wait_ack(1'b0);
    rdat = rd;
    #4 sel_n = 1'b1;
    wait_ack(1'b1);
  endtask : acc
  // Bounded wait for a bit total; notes any activity on channel three's outer pair
  task automatic rx_wait(input logic [5:0] n);
    for (int i = 0; i < 2000 && rx_bits !== n; i++) begin
      @(posedge clk_in);
      ext = ext | ones[2] | zeros[2];
    end
  endtask : rx_wait
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    #5 rst_n_in = 1'b1;
    acc(1'b1, 4'h1, 16'h0);
    chk(rdat, 16'h0);
    acc(1'b1, 4'hC, 16'h0);
    chk(rdat, 16'hFC00);
    chk(irq, 1'b1);
    acc(1'b0, 4'h1, 16'h0010);
    repeat (9) begin
      acc(1'b0, 4'h2, 16'h1234);
      acc(1'b0, 4'h3, 16'h5678);
    end
    acc(1'b1, 4'h1, 16'h0);
    chk(rdat, 16'h0018);
    acc(1'b1, 4'hC, 16'h0);
    chk(rdat[11:10], 2'h0);
    acc(1'b0, 4'h1, 16'h0);
    acc(1'b1, 4'h1, 16'h0);
    chk(rdat, 16'h0);
    acc(1'b0, 4'h8, 16'h0002);
    acc(1'b0, 4'h9, 16'hC410);
    acc(1'b0, 4'hA, 16'h0000);
    acc(1'b0, 4'hB, 16'h0001);
    rx_wait(6'h20);
    chk(rx_word, 32'h80000001);
    // Odd parity with a gap; enable toggled first as the host must
    acc(1'b0, 4'h9, 16'h4C50);
    acc(1'b0, 4'h9, 16'hCC50);
    acc(1'b0, 4'hA, 16'hC000);
    acc(1'b0, 4'hB, 16'h0003);
    rx_wait(6'h00);
    chk(rx_word, 32'h40000003);
    chk(ext, 1'b0);
    summarize();
  end
  // Watchdog well beyond the expected run
  initial begin
    #200000 error_cnt++;
    $display("Error %0t: timeout", $time);
    summarize();
  end
endmodule : tb_transmit_channel_unit
bind transmit_channel_unit tcu_checker #(.CHANNELS(CHANNELS)) tcu_checker_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_sel_n_in(bus_sel_n_in),
  .bus_ack_n_out(bus_ack_n_out), .bus_data_oe_n_out(bus_data_oe_n_out),
  .tx_ones_line_out(tx_ones_line_out), .tx_zeros_line_out(tx_zeros_line_out),
  .loopback_ones_line_out(loopback_ones_line_out),
  .loopback_zeros_line_out(loopback_zeros_line_out));

// ---- verif/tcu_checker.sv ----
/* Port-level checks of the transmitter unit.
   Assumes a bind onto its top; divider 2 on the sending channel. */
`timescale 1ns/1ns
module tcu_checker #(
  parameter int CHANNELS = 3
) (
  // Clock, reset, host port
  input wire logic                clk_in,
  input wire logic                rst_n_in,
  input wire logic                bus_sel_n_in,
  input wire logic                bus_ack_n_out,
  input wire logic                bus_data_oe_n_out,
  // Serial lines
  input wire logic [CHANNELS-1:0] tx_ones_line_out,
  input wire logic [CHANNELS-1:0] tx_zeros_line_out,
  input wire logic                loopback_ones_line_out,
  input wire logic                loopback_zeros_line_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////
  // Both loop lines stay low for the two cycles after a pulse ends
  sequence low_tail;
    (!loopback_ones_line_out && !loopback_zeros_line_out)[*2];
  endsequence
  a_pair_exclusive: assert property (!(|(tx_ones_line_out & tx_zeros_line_out)))
    else $error("pair clash");
  a_loop_quiet: assert property (loopback_ones_line_out |-> !tx_ones_line_out[2])
    else $error("ch3 driven");
  a_loop_quiet_zero: assert property (loopback_zeros_line_out |-> !tx_zeros_line_out[2])
    else $error("ch3 driven");
  a_ones_return: assert property ($rose(loopback_ones_line_out) |-> ##[1:40] !loopback_ones_line_out)
    else $error("ones stuck");
  a_ones_tail: assert property ($fell(loopback_ones_line_out) |-> low_tail)
    else $error("ones tail");
  a_zeros_tail: assert property ($fell(loopback_zeros_line_out) |-> low_tail)
    else $error("zeros tail");
  a_ack_cause: assert property ($fell(bus_ack_n_out) |-> !$past(bus_sel_n_in, 3))
    else $error("ack timing");
  a_drive_acked: assert property ($fell(bus_data_oe_n_out) |-> $fell(bus_ack_n_out))
    else $error("drive timing");
endmodule : tcu_checker

// ---- verilog/tcu_pkg.sv ----
/*
  Shared constants and types for the three-channel serial word transmitter:
  register map, control field layout, reset values, queue sizes, states.
  Assumes a 16-bit host register port with word addressing and 32-bit messages.
*/
package tcu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int CHANNELS    = 3;
  localparam int QUEUE_DEPTH = 8;
  localparam int MSG_W       = 32;
  localparam int HALF_W      = 16;
  localparam int ADDR_W      = 4;
  localparam int CNT_W       = 4;
  localparam int GAP_W       = 5;
  localparam int LOOP_CHAN   = 2;   // Zero-based index of the third channel

  ////////////////////////////////////////////////////////////////////////////
  // Register map, word addresses: channel base is index times stride
  localparam int                CH_STRIDE       = 4;
  localparam logic [1:0]        OFS_DIVIDER     = 2'h0;
  localparam logic [1:0]        OFS_CONTROL     = 2'h1;
  localparam logic [1:0]        OFS_QUEUE_UPPER = 2'h2;
  localparam logic [1:0]        OFS_QUEUE_LOWER = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 4'hC;

  ////////////////////////////////////////////////////////////////////////////
  // Status word field positions, per channel index c
  localparam int STAT_EMPTY_BASE = 11;   // Empty flag at 11 + 2c
  localparam int STAT_EOT_BASE   = 10;   // End of transmission at 10 + 2c
  localparam int STAT_STEP       = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and queue count constants
  localparam logic [HALF_W-1:0] DIVIDER_RESET = 16'h0000;
  localparam logic [HALF_W-1:0] CONTROL_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE       = 4'h1;
  localparam logic [CNT_W-1:0]  CNT_FULL      = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Control register layout, bit 15 down to bit 0
  typedef struct packed {
    logic             enable;     // 15
    logic             test;       // 14
    logic [1:0]       unused;     // 13..12
    logic             odd;        // 11
    logic             par_en;     // 10
    logic [GAP_W-1:0] gap;        // 9..5
    logic             fifo_run;   // 4, zero holds the queue in reset
    logic [CNT_W-1:0] count;      // 3..0, read only
  } ctrl_t;

  // Host pins as sampled together through the synchroniser
  typedef struct packed {
    logic              sel_n;
    logic              rw;
    logic              uds_n;
    logic              lds_n;
    logic [ADDR_W-1:0] addr;
    logic [HALF_W-1:0] data;
  } bus_pins_t;

  localparam bus_pins_t BUS_IDLE = '{sel_n: 1'b1, rw: 1'b1, uds_n: 1'b1,
                                     lds_n: 1'b1, addr: 4'h0, data: 16'h0000};

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP} tx_state_t;

endpackage : tcu_pkg

// ---- verilog/transmit_channel_unit.sv ----
/*
  Three-channel serial word transmitter: host register port, eight-message
  queue per channel, bit rate divider, parity, gap and return-to-zero lines.
  Assumes host and reference clock pins are asynchronous to clk_in and are
  synchronised here; an external driver combines each line pair.
*/
`timescale 1ns/1ns
module transmit_channel_unit #(
  parameter int CHANNELS    = tcu_pkg::CHANNELS,
  parameter int QUEUE_DEPTH = tcu_pkg::QUEUE_DEPTH
) (
  // Clock, reset, enable
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        ce_in,
  // Reference clock pin
  input  wire logic                        avionics_reference_clock_in,
  // Host register port pins
  input  wire logic                        bus_sel_n_in,
  input  wire logic                        bus_rw_in,
  input  wire logic                        upper_ds_n_in,
  input  wire logic                        lower_ds_n_in,
  input  wire logic [tcu_pkg::ADDR_W-1:0]  bus_addr_in,
  input  wire logic [tcu_pkg::HALF_W-1:0]  bus_data_in,
  output logic      [tcu_pkg::HALF_W-1:0]  bus_data_out,
  output logic                             bus_data_oe_n_out,
  output logic                             bus_ack_n_out,
  // Interrupt gating from the interrupt unit
  input  wire logic [5:0]                  tx_irq_mask_in,
  output logic                             transmit_interrupt_request_out,
  // Serial lines
  output logic      [CHANNELS-1:0]         tx_ones_line_out,
  output logic      [CHANNELS-1:0]         tx_zeros_line_out,
  output logic                             loopback_ones_line_out,
  output logic                             loopback_zeros_line_out
);

  localparam int PTR_W = $clog2(QUEUE_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Merge a write into a register through the byte lane strobes
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic        upper,
                                             input logic        lower);
    logic [15:0] r;
    r = old_v;
    if (upper) r[15:8] = new_v[15:8];
    if (lower) r[7:0] = new_v[7:0];
    return r;
  endfunction : lane_merge

  // Force the top bit so the whole word meets the chosen parity
  function automatic logic [31:0] apply_parity(input logic [31:0] word,
                                               input logic        en,
                                               input logic        odd);
    logic [31:0] r;
    r = word;
    if (en) r[31] = (^word[30:0]) ^ odd;
    return r;
  endfunction : apply_parity

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; second stage is the only reader of the first
  tcu_pkg::bus_pins_t pins_s1_ff;
  tcu_pkg::bus_pins_t pins_s2_ff;
  logic               ref_s1_ff;
  logic               ref_s2_ff;
  logic               ref_s3_ff;
  logic               ref_edge;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins_s1_ff <= tcu_pkg::BUS_IDLE;
      pins_s2_ff <= tcu_pkg::BUS_IDLE;
    end else if (ce_in) begin
      pins_s1_ff <= '{sel_n: bus_sel_n_in, rw: bus_rw_in, uds_n: upper_ds_n_in,
                      lds_n: lower_ds_n_in, addr: bus_addr_in, data: bus_data_in};
      pins_s2_ff <= pins_s1_ff;
    end
  end

  // Reference clock sampled; rising edge becomes a one-cycle pulse
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      ref_s3_ff <= 1'b0;
    end else if (ce_in) begin
      ref_s1_ff <= avionics_reference_clock_in;
      ref_s2_ff <= ref_s1_ff;
      ref_s3_ff <= ref_s2_ff;
    end
  end

  assign ref_edge = ref_s2_ff && !ref_s3_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Host access handshake: one action per strobe assertion
  logic                        access;
  logic                        start;
  logic                        wr_pulse;
  logic                        both_lanes;
  logic                        ack_ff;
  logic                        oe_n_ff;
  logic [tcu_pkg::HALF_W-1:0]  rd_data_ff;
  logic [tcu_pkg::HALF_W-1:0]  rd_mux;
  logic [tcu_pkg::HALF_W-1:0]  status_word;
  logic [tcu_pkg::HALF_W-1:0]  ctrl_rd [CHANNELS];

  assign access     = !pins_s2_ff.sel_n && (!pins_s2_ff.uds_n || !pins_s2_ff.lds_n);
  assign start      = access && !ack_ff;
  assign wr_pulse   = start && !pins_s2_ff.rw;
  assign both_lanes = !pins_s2_ff.uds_n && !pins_s2_ff.lds_n;

  // Acknowledge stays until the host drops its strobes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_ff     <= 1'b0;
      oe_n_ff    <= 1'b1;
      rd_data_ff <= 16'h0000;
    end else if (ce_in) begin
      ack_ff  <= access;
      oe_n_ff <= !(access && pins_s2_ff.rw);
      if (start && pins_s2_ff.rw) begin
        rd_data_ff <= rd_mux;
      end
    end
  end

  assign bus_ack_n_out     = !ack_ff;
  assign bus_data_oe_n_out = oe_n_ff;
  assign bus_data_out      = rd_data_ff;

  // Read decode; write-only and unmapped words read zero
  always_comb begin
    rd_mux = 16'h0000;
    if (pins_s2_ff.addr == tcu_pkg::ADDR_STATUS) begin
      rd_mux = status_word;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (pins_s2_ff.addr == 4'(c * tcu_pkg::CH_STRIDE + 1)) begin
          rd_mux = ctrl_rd[c];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  logic [CHANNELS-1:0] empty_flag;
  logic [CHANNELS-1:0] eot_flag;
  logic [CHANNELS-1:0] ones_ff;
  logic [CHANNELS-1:0] zeros_ff;
  logic [CHANNELS-1:0] test_on;

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    logic [tcu_pkg::HALF_W-1:0] divider_ff;
    tcu_pkg::ctrl_t             ctrl_ff;
    logic [tcu_pkg::HALF_W-1:0] upper_hold_ff;
    logic [tcu_pkg::MSG_W-1:0]  mem [QUEUE_DEPTH];
    logic [PTR_W-1:0]           wr_ptr_ff;
    logic [PTR_W-1:0]           rd_ptr_ff;
    logic [PTR_W:0]             mem_cnt_ff;
    logic [tcu_pkg::CNT_W-1:0]  msg_cnt_ff;
    tcu_pkg::tx_state_t         state_ff;
    logic [tcu_pkg::HALF_W-1:0] phase_ff;
    logic [4:0]                 bit_idx_ff;
    logic [tcu_pkg::GAP_W-1:0]  gap_cnt_ff;
    logic [tcu_pkg::MSG_W-1:0]  shift_ff;
    logic                       here;
    logic                       push;
    logic                       pop;
    logic                       load;
    logic                       bit_end;
    logic                       first_half;
    logic                       buf_in_ready;
    logic                       buf_out_valid;
    logic [tcu_pkg::MSG_W-1:0]  buf_out_data;

    assign here = wr_pulse && (pins_s2_ff.addr[3:2] == 2'(ch));
    // Full 16-bit writes only; lower half completes the message
    assign push = here && (pins_s2_ff.addr[1:0] == tcu_pkg::OFS_QUEUE_LOWER)
                  && both_lanes && ctrl_ff.fifo_run
                  && (msg_cnt_ff < tcu_pkg::CNT_FULL);
    assign pop  = (mem_cnt_ff != '0) && buf_in_ready && ctrl_ff.fifo_run;
    assign load = (state_ff == tcu_pkg::TX_IDLE) && ctrl_ff.enable
                  && ctrl_ff.fifo_run && buf_out_valid;

    // Divider and control written through byte lanes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        divider_ff <= tcu_pkg::DIVIDER_RESET;
        ctrl_ff    <= tcu_pkg::CONTROL_RESET;
      end else if (ce_in && here) begin
        if (pins_s2_ff.addr[1:0] == tcu_pkg::OFS_DIVIDER) begin
          divider_ff <= lane_merge(divider_ff, pins_s2_ff.data,
                                   !pins_s2_ff.uds_n, !pins_s2_ff.lds_n);
        end else if (pins_s2_ff.addr[1:0] == tcu_pkg::OFS_CONTROL) begin
          ctrl_ff        <= lane_merge(ctrl_ff, pins_s2_ff.data,
                                       !pins_s2_ff.uds_n, !pins_s2_ff.lds_n);
          ctrl_ff.unused <= 2'h0;
          ctrl_ff.count  <= 4'h0;
          if (ch != tcu_pkg::LOOP_CHAN) begin
            ctrl_ff.test <= 1'b0;
          end
        end
      end
    end

    // Upper half waits for its lower half
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        upper_hold_ff <= 16'h0000;
      end else if (ce_in && here && both_lanes
                   && (pins_s2_ff.addr[1:0] == tcu_pkg::OFS_QUEUE_UPPER)) begin
        upper_hold_ff <= pins_s2_ff.data;
      end
    end

    // Message store; no reset needed on data words
    always_ff @(posedge clk_in) begin
      if (ce_in && push) begin
        mem[wr_ptr_ff] <= {upper_hold_ff, pins_s2_ff.data};
      end
    end

    // Queue pointers; a cleared reset bit keeps them flushed
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        wr_ptr_ff  <= '0;
        rd_ptr_ff  <= '0;
        mem_cnt_ff <= '0;
      end else if (ce_in) begin
        if (!ctrl_ff.fifo_run) begin
          wr_ptr_ff  <= '0;
          rd_ptr_ff  <= '0;
          mem_cnt_ff <= '0;
        end else begin
          if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
          if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
          if (push && !pop) begin
            mem_cnt_ff <= mem_cnt_ff + 1'b1;
          end else if (pop && !push) begin
            mem_cnt_ff <= mem_cnt_ff - 1'b1;
          end
        end
      end
    end

    // Visible count covers the memory and the buffer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        msg_cnt_ff <= 4'h0;
      end else if (ce_in) begin
        if (!ctrl_ff.fifo_run) begin
          msg_cnt_ff <= 4'h0;
        end else if (push && !load) begin
          msg_cnt_ff <= msg_cnt_ff + tcu_pkg::CNT_ONE;
        end else if (load && !push) begin
          msg_cnt_ff <= msg_cnt_ff - tcu_pkg::CNT_ONE;
        end
      end
    end

    // Buffer lets the shifter stall without losing a popped word
    two_entry_buffer #(.WIDTH(tcu_pkg::MSG_W)) u_buf (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .ce_in         (ce_in),
      .flush_in      (!ctrl_ff.fifo_run),
      .in_valid_in   (pop),
      .in_ready_out  (buf_in_ready),
      .in_data_in    (mem[rd_ptr_ff]),
      .out_valid_out (buf_out_valid),
      .out_ready_in  (load),
      .out_data_out  (buf_out_data)
    );

    // Bit timing counts reference edges up to the divider value
    assign bit_end    = ref_edge && (phase_ff == divider_ff - 16'h0001);
    assign first_half = phase_ff < (divider_ff >> 1);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        phase_ff <= 16'h0000;
      end else if (ce_in) begin
        if (state_ff == tcu_pkg::TX_IDLE || !ctrl_ff.enable) begin
          phase_ff <= 16'h0000;
        end else if (bit_end) begin
          phase_ff <= 16'h0000;
        end else if (ref_edge) begin
          phase_ff <= phase_ff + 16'h0001;
        end
      end
    end

    // Message sequencer: send 32 bits, then the gap
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        state_ff   <= tcu_pkg::TX_IDLE;
        bit_idx_ff <= 5'h00;
        gap_cnt_ff <= 5'h00;
        shift_ff   <= 32'h0000_0000;
      end else if (ce_in) begin
        if (!ctrl_ff.enable) begin
          state_ff <= tcu_pkg::TX_IDLE;
        end else begin
          case (state_ff)
            tcu_pkg::TX_IDLE: begin
              if (load) begin
                shift_ff   <= apply_parity(buf_out_data, ctrl_ff.par_en,
                                           ctrl_ff.odd);
                bit_idx_ff <= 5'h00;
                state_ff   <= tcu_pkg::TX_SEND;
              end
            end
            tcu_pkg::TX_SEND: begin
              if (bit_end) begin
                shift_ff   <= shift_ff >> 1;
                bit_idx_ff <= bit_idx_ff + 5'h01;
                if (bit_idx_ff == 5'h1F) begin
                  gap_cnt_ff <= 5'h00;
                  state_ff   <= (ctrl_ff.gap == 5'h00) ? tcu_pkg::TX_IDLE
                                                       : tcu_pkg::TX_GAP;
                end
              end
            end
            tcu_pkg::TX_GAP: begin
              if (bit_end) begin
                gap_cnt_ff <= gap_cnt_ff + 5'h01;
                if (gap_cnt_ff == ctrl_ff.gap - 5'h01) begin
                  state_ff <= tcu_pkg::TX_IDLE;
                end
              end
            end
            default: begin
              state_ff <= tcu_pkg::TX_IDLE;
            end
          endcase
        end
      end
    end

    // Return-to-zero pulse in the first half of each bit
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        ones_ff[ch]  <= 1'b0;
        zeros_ff[ch] <= 1'b0;
      end else if (ce_in) begin
        ones_ff[ch]  <= ctrl_ff.enable && (state_ff == tcu_pkg::TX_SEND)
                        && first_half && shift_ff[0];
        zeros_ff[ch] <= ctrl_ff.enable && (state_ff == tcu_pkg::TX_SEND)
                        && first_half && !shift_ff[0];
      end
    end

    // Status and read-back
    assign empty_flag[ch] = (msg_cnt_ff == 4'h0);
    assign eot_flag[ch]   = empty_flag[ch] && (state_ff == tcu_pkg::TX_IDLE);
    assign test_on[ch]    = ctrl_ff.test;
    assign ctrl_rd[ch]    = {ctrl_ff[15:4], msg_cnt_ff};
  end : g_chan

  ////////////////////////////////////////////////////////////////////////////
  // Status word and interrupt request
  always_comb begin
    status_word = 16'h0000;
    for (int c = 0; c < CHANNELS; c++) begin
      status_word[tcu_pkg::STAT_EMPTY_BASE + tcu_pkg::STAT_STEP * c] = empty_flag[c];
      status_word[tcu_pkg::STAT_EOT_BASE + tcu_pkg::STAT_STEP * c]   = eot_flag[c];
    end
  end

  // Level request while any unmasked flag stands
  assign transmit_interrupt_request_out = |(status_word[15:10] & tx_irq_mask_in);

  ////////////////////////////////////////////////////////////////////////////
  // Line routing; the third channel can be turned inward
  always_comb begin
    tx_ones_line_out  = ones_ff;
    tx_zeros_line_out = zeros_ff;
    if (test_on[tcu_pkg::LOOP_CHAN]) begin
      tx_ones_line_out[tcu_pkg::LOOP_CHAN]  = 1'b0;
      tx_zeros_line_out[tcu_pkg::LOOP_CHAN] = 1'b0;
    end
  end

  // Receivers select these lines when in their own test mode
  assign loopback_ones_line_out  = test_on[tcu_pkg::LOOP_CHAN]
                                   && ones_ff[tcu_pkg::LOOP_CHAN];
  assign loopback_zeros_line_out = test_on[tcu_pkg::LOOP_CHAN]
                                   && zeros_ff[tcu_pkg::LOOP_CHAN];

endmodule : transmit_channel_unit

// ---- verilog/two_entry_buffer.sv ----
/*
  Two-slot buffer with valid/ready on both sides and a synchronous flush.
  Assumes one clock, a clock enable that freezes it, and a flush that wins.
*/
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             flush_in,
  // Filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  logic [WIDTH-1:0] slot_ff [2];
  logic             wr_sel_ff;
  logic             rd_sel_ff;
  logic [1:0]       fill_ff;
  logic             take;
  logic             give;

  // Honest full and empty
  assign in_ready_out  = (fill_ff != 2'h2);
  assign out_valid_out = (fill_ff != 2'h0);
  assign out_data_out  = slot_ff[rd_sel_ff];
  assign take          = in_valid_in && in_ready_out;
  assign give          = out_valid_out && out_ready_in;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pointers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_ff[0] <= '0;
      slot_ff[1] <= '0;
      wr_sel_ff  <= 1'b0;
      rd_sel_ff  <= 1'b0;
      fill_ff    <= 2'h0;
    end else if (ce_in) begin
      if (flush_in) begin
        wr_sel_ff <= 1'b0;
        rd_sel_ff <= 1'b0;
        fill_ff   <= 2'h0;
      end else begin
        if (take) begin
          slot_ff[wr_sel_ff] <= in_data_in;
          wr_sel_ff          <= ~wr_sel_ff;
        end
        if (give) begin
          rd_sel_ff <= ~rd_sel_ff;
        end
        // Simultaneous take and give leaves the fill unchanged
        if (take && !give) begin
          fill_ff <= fill_ff + 2'h1;
        end else if (give && !take) begin
          fill_ff <= fill_ff - 2'h1;
        end
      end
    end
  end

endmodule : two_entry_buffer
